// file: kbu_keyboard_interrupt_unit.sv
// Keyboard interrupt unit: six maskable key pins, one latched
// request, edge or edge-and-level triggering, acknowledge by
// vector fetch or by software, plus a merged wakeup request.
// Assumes a one-cycle register port and a CPU vector-fetch pulse.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module kbu_keyboard_interrupt_unit #(
	parameter int PINS = 6
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Port pins
	input wire logic [PINS-1:0] port_a_pins,
	input wire logic [PINS-1:0] port_pullup_enable,
	output logic [PINS-1:0] pullup_on,
	// Wakeup source
	input wire logic auto_wakeup_request,
	// CPU side
	input wire logic vector_fetch,
	output logic cpu_request,
	output logic [15:0] vector_address,
	// Event interrupt
	output logic irq
);

	// ----------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------
	logic [PINS-1:0] pins_sync;
	logic [PINS-1:0] pin_interrupt_enable;
	logic auto_wakeup_enable;
	logic [6:0] enable_q;
	logic [6:0] enable_d;
	logic interrupt_mask_q;
	logic interrupt_mask_d;
	logic trigger_level_select_q;
	logic trigger_level_select_d;
	logic pending_q;
	logic pending_d;
	logic ack_seen_q;
	logic ack_seen_d;
	logic wake_q;
	logic wake_d;
	logic none_q;
	logic none_d;
	logic [1:0] ev_status_q;
	logic [1:0] ev_status_d;
	logic [1:0] ev_mask_q;
	logic [1:0] ev_mask_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [15:0] vector_q;
	logic [15:0] vector_d;
	logic any_active;
	logic edge_set;
	logic ack_write;
	logic ack;
	logic ack_done;

	// ----------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ----------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------
	// pins crossed into the bus clock
	kbu_sync #(
		.WIDTH(PINS),
		.RESET_VALUE({PINS{1'b1}})
	) u_sync (
		.clock(clock),
		.reset(reset),
		.async_in(port_a_pins),
		.sync_out(pins_sync)
	);

	// ----------------------------------------------------------
	// Pin enables and pullups
	// ----------------------------------------------------------
	// one enable bit per port pin
	assign pin_interrupt_enable = enable_q[PINS-1:0];
	assign auto_wakeup_enable = enable_q[kbu_pkg::KBU_AUTO_WAKEUP_EN_BIT];

	assign pullup_on = pin_interrupt_enable | port_pullup_enable;

	// ----------------------------------------------------------
	// Request detection
	// ----------------------------------------------------------
	// Wakeup request counts as one more low input
	// only enabled pins take part
	assign any_active = (|(pin_interrupt_enable & ~pins_sync)) | wake_q;

	// no set while another input already low
	// fresh edge after acknowledge still sets
	assign edge_set = any_active & none_q;

	assign ack_write = reg_write &
		hit(reg_addr, kbu_pkg::KBU_KEY_STATUS_CONTROL) &
		reg_wdata[kbu_pkg::KBU_REQUEST_ACK_BIT];

	assign ack = vector_fetch | ack_write;
	assign ack_done = ack | ack_seen_q;

	always_comb begin
		none_d = ~any_active;
		ack_seen_d = ack_seen_q;
		pending_d = pending_q;
		if (trigger_level_select_q) begin
			// both acknowledge and release, any order
			pending_d = edge_set | any_active |
				(pending_q & ~ack_done);
			if (!pending_d)
				ack_seen_d = 1'b0;
			else if (ack)
				ack_seen_d = 1'b1;
		end else begin
			// edge mode clears on acknowledge at once
			// Set wins over a clear in the same cycle
			pending_d = edge_set | (pending_q & ~ack);
			ack_seen_d = 1'b0;
		end
	end

	// reset clears request whatever the pins show
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pending_q <= 1'b0;
			ack_seen_q <= 1'b0;
			none_q <= 1'b1;
		end else begin
			pending_q <= pending_d;
			ack_seen_q <= ack_seen_d;
			none_q <= none_d;
		end
	end

	// ----------------------------------------------------------
	// Wakeup request latch
	// ----------------------------------------------------------
	// only software acknowledge or reset clears it
	always_comb begin
		wake_d = (auto_wakeup_request & auto_wakeup_enable) |
			(wake_q & ~ack_write);
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			wake_q <= 1'b0;
		else
			wake_q <= wake_d;
	end

	// ----------------------------------------------------------
	// CPU request and vector
	// ----------------------------------------------------------
	// unmasked pending request points at the vector
	assign cpu_request = pending_q & ~interrupt_mask_q;

	always_comb begin
		vector_d = kbu_pkg::KBU_VECTOR_ADDR;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			vector_q <= kbu_pkg::KBU_VECTOR_ADDR;
		else
			vector_q <= vector_d;
	end

	assign vector_address = vector_q;

	// ----------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------
	always_comb begin
		enable_d = enable_q;
		interrupt_mask_d = interrupt_mask_q;
		trigger_level_select_d = trigger_level_select_q;
		ev_mask_d = ev_mask_q;
		if (reg_write) begin
			if (hit(reg_addr, kbu_pkg::KBU_KEY_STATUS_CONTROL)) begin
				interrupt_mask_d =
					reg_wdata[kbu_pkg::KBU_INTERRUPT_MASK_BIT];
				trigger_level_select_d =
					reg_wdata[kbu_pkg::KBU_TRIGGER_LEVEL_BIT];
			end
			if (hit(reg_addr, kbu_pkg::KBU_KEY_ENABLE_REGISTER))
				enable_d = reg_wdata[6:0];
			if (hit(reg_addr, kbu_pkg::KBU_EVENT_MASK))
				ev_mask_d = reg_wdata[1:0];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			enable_q <= kbu_pkg::KBU_ENABLE_RESET;
			interrupt_mask_q <= 1'b0;
			trigger_level_select_q <= 1'b0;
			ev_mask_q <= kbu_pkg::KBU_EV_RESET;
		end else begin
			enable_q <= enable_d;
			interrupt_mask_q <= interrupt_mask_d;
			trigger_level_select_q <= trigger_level_select_d;
			ev_mask_q <= ev_mask_d;
		end
	end

	// ----------------------------------------------------------
	// Event status and interrupt
	// ----------------------------------------------------------
	// Read clears; a new event in the read cycle survives
	always_comb begin
		ev_status_d = ev_status_q;
		if (reg_read && hit(reg_addr, kbu_pkg::KBU_EVENT_STATUS))
			ev_status_d = kbu_pkg::KBU_EV_RESET;
		if (pending_d && !pending_q)
			ev_status_d[kbu_pkg::KBU_EV_KEY_BIT] = 1'b1;
		if (wake_d && !wake_q)
			ev_status_d[kbu_pkg::KBU_EV_WAKE_BIT] = 1'b1;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			ev_status_q <= kbu_pkg::KBU_EV_RESET;
		else
			ev_status_q <= ev_status_d;
	end

	assign irq = |(ev_status_q & ev_mask_q);

	// ----------------------------------------------------------
	// Read data
	// ----------------------------------------------------------
	always_comb begin
		rdata_d = kbu_pkg::KBU_RDATA_RESET;
		if (reg_read) begin
			if (hit(reg_addr, kbu_pkg::KBU_KEY_STATUS_CONTROL)) begin
				rdata_d[kbu_pkg::KBU_PENDING_FLAG_BIT] = pending_q;
				rdata_d[kbu_pkg::KBU_INTERRUPT_MASK_BIT] =
					interrupt_mask_q;
				rdata_d[kbu_pkg::KBU_TRIGGER_LEVEL_BIT] =
					trigger_level_select_q;
			end
			if (hit(reg_addr, kbu_pkg::KBU_KEY_ENABLE_REGISTER))
				rdata_d[6:0] = enable_q;
			if (hit(reg_addr, kbu_pkg::KBU_EVENT_STATUS))
				rdata_d[1:0] = ev_status_q;
			if (hit(reg_addr, kbu_pkg::KBU_EVENT_MASK))
				rdata_d[1:0] = ev_mask_q;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			rdata_q <= kbu_pkg::KBU_RDATA_RESET;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata = rdata_q;

	// ----------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_all_high_then_fall;
		none_q ##0 any_active;
	endsequence

	sequence s_edge_ack;
		!trigger_level_select_q && ack && !edge_set;
	endsequence

	a_pullup_forced: assert property (
		!(|(pin_interrupt_enable & ~pullup_on)))
		else $error("enabled key pin without pullup");

	a_edge_latch: assert property (
		s_all_high_then_fall |=> pending_q)
		else $error("falling key edge not latched");

	// no latch while another input low
	a_edge_blocked: assert property (
		(!trigger_level_select_q && !none_q && !pending_q)
		|=> !pending_q)
		else $error("edge mode latched while input low");

	a_level_hold: assert property (
		(trigger_level_select_q && any_active) |=> pending_q)
		else $error("level request dropped while input low");

	a_level_clear: assert property (
		(trigger_level_select_q && pending_q && !ack && !ack_seen_q)
		|=> pending_q)
		else $error("level request cleared without acknowledge");

	a_edge_ack: assert property (
		s_edge_ack |=> !pending_q)
		else $error("edge mode acknowledge did not clear");

	a_soft_ack: assert property (
		(ack_write && !trigger_level_select_q && !edge_set)
		|=> !pending_q ##1 !pending_q || $past(edge_set))
		else $error("software acknowledge did not clear");

	a_wake_keep: assert property (
		(wake_q && !ack_write) |=> wake_q)
		else $error("wakeup request lost without software ack");

	a_cpu_vector: assert property (
		cpu_request |-> (vector_address == 16'hFFE0) &&
		!interrupt_mask_q)
		else $error("cpu request without vector or while masked");

	a_ctrl_read: assert property (
		(reg_read && reg_addr == 8'h1A) |=>
		reg_rdata == {4'h0, $past(pending_q), 1'b0,
		$past(interrupt_mask_q), $past(trigger_level_select_q)})
		else $error("status control read mismatch");

endmodule // kbu_keyboard_interrupt_unit

// file: kbu_pkg.sv
// Package: register map, field positions, reset values and widths
// of the keyboard interrupt unit.
// Assumes an 8-bit register port with byte-wide data.
package kbu_pkg;

	// ----------------------------------------------------------
	// Widths
	// ----------------------------------------------------------
	localparam int KBU_ADDR_W = 8;
	localparam int KBU_DATA_W = 8;
	localparam int KBU_PINS = 6;
	localparam int KBU_SYNC_STAGES = 2;

	// ----------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------
	localparam logic [7:0] KBU_KEY_STATUS_CONTROL = 8'h1A;
	localparam logic [7:0] KBU_KEY_ENABLE_REGISTER = 8'h1B;
	localparam logic [7:0] KBU_EVENT_STATUS = 8'h30;
	localparam logic [7:0] KBU_EVENT_MASK = 8'h31;

	// ----------------------------------------------------------
	// Fields of key_status_control
	// ----------------------------------------------------------
	localparam int KBU_PENDING_FLAG_BIT = 3;
	localparam int KBU_REQUEST_ACK_BIT = 2;
	localparam int KBU_INTERRUPT_MASK_BIT = 1;
	localparam int KBU_TRIGGER_LEVEL_BIT = 0;

	// ----------------------------------------------------------
	// Fields of key_enable_register
	// ----------------------------------------------------------
	localparam int KBU_AUTO_WAKEUP_EN_BIT = 6;
	localparam int KBU_ENABLE_W = 7;

	// ----------------------------------------------------------
	// Fields of the event status and mask registers
	// ----------------------------------------------------------
	localparam int KBU_EV_KEY_BIT = 0;
	localparam int KBU_EV_WAKE_BIT = 1;
	localparam int KBU_EV_W = 2;

	// ----------------------------------------------------------
	// Reset values and the keyboard vector
	// ----------------------------------------------------------
	localparam logic [6:0] KBU_ENABLE_RESET = 7'h00;
	localparam logic [1:0] KBU_EV_RESET = 2'h0;
	localparam logic [7:0] KBU_RDATA_RESET = 8'h00;
	localparam logic [15:0] KBU_VECTOR_ADDR = 16'hFFE0;

endpackage

// file: kbu_sync.sv
// Synchroniser for a group of level inputs.
// Assumes inputs may change at any time relative to clock.
`timescale 1ns/1ps
module kbu_sync #(
	parameter int WIDTH = 6,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ----------------------------------------------------------
	// Two stages
	// ----------------------------------------------------------
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Reset as idle high so no false edge after release
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_q <= RESET_VALUE;
			sync_q <= RESET_VALUE;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule // kbu_sync

// file: kbu_keys.sv
// Key switch model standing on the port A pins.
// Assumes pullup_on comes from the unit and press from the bench.
`timescale 1ns/1ps
module kbu_keys (
	// Clock
	input wire logic clock,
	// Keys and pullups
	input wire logic [5:0] press,
	input wire logic [5:0] pullup_on,
	output logic [5:0] pins
);
	logic [5:0] last_q = 6'h00;

	// ----------------------------------------------------------
	// Pin levels
	// ----------------------------------------------------------
	// bench may release held key
	// Open pin with no pullup wanders, never a stale level
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pins[i] = press[i] ? 1'b0 : (pullup_on[i] ? 1'b1 : ~last_q[i]);
		end
	end

	always_ff @(posedge clock) begin
		last_q <= pins;
	end
endmodule // kbu_keys

// file: testbench.sv
// Self-checking bench of the keyboard interrupt unit.
// Assumes the key model on the pins and a fixed random seed.
`timescale 1ns/1ps
module testbench;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic [5:0] pins;
	logic [5:0] pue = 6'h3F;
	logic [5:0] pullup_on;
	logic [5:0] press = 6'h00;
	logic awu = 1'b0;
	logic vf = 1'b0;
	logic cpu_request;
	logic [15:0] vector_address;
	logic irq;
	logic [6:0] en;
	logic [2:0] k;
	logic [2:0] j;
	logic [7:0] d;
	int n_errors = 0;
	int cmp_count = 0;
	int seed = 59;

	always #5 clock = ~clock;

	kbu_keyboard_interrupt_unit dut (.clock(clock), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .port_a_pins(pins),
		.port_pullup_enable(pue), .pullup_on(pullup_on),
		.auto_wakeup_request(awu), .vector_fetch(vf),
		.cpu_request(cpu_request), .vector_address(vector_address),
		.irq(irq));
	kbu_keys keys (.clock(clock), .press(press), .pullup_on(pullup_on),
		.pins(pins));

	// ----------------------------------------------------------
	// Checks and expectations
	// ----------------------------------------------------------
	task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		chk_sig({8'h00, got}, {8'h00, exp});
	endtask
	function automatic logic [7:0] scr(input logic p, m, l);
		return {4'h0, p, 1'b0, m, l};
	endfunction
	function automatic logic [5:0] pull(input logic [6:0] e,
		input logic [5:0] p);
		return e[5:0] | p;
	endfunction

	// ----------------------------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk_reg(v, e);
	endtask
	task automatic ack(input logic l);
		wr(8'h1A, {5'h00, 1'b1, 1'b0, l});
	endtask
	task automatic vfetch();
		@(posedge clock);
		vf <= 1'b1;
		@(posedge clock);
		vf <= 1'b0;
	endtask
	task automatic arm(input logic [6:0] e, input logic l);
		wr(8'h1B, {1'b0, e});
		cyc(5);
		ack(l);
	endtask
	task automatic end_of_test();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		cyc(12);
		reset <= 1'b0;
		rdchk(8'h1A, scr(0, 0, 0));
		rdchk(8'h1B, 8'h00);
		chk_sig(vector_address, 16'hFFE0);
		rdchk(8'h55, 8'h00);
		// Random enables, pullups forced on enabled pins
		for (int i = 0; i < 8; i++) begin
			cyc(1);
			en = 7'($random(seed));
			pue <= 6'($random(seed));
			wr(8'h1B, {1'b0, en});
			rdchk(8'h1B, {1'b0, en});
			chk_sig(16'(pullup_on), 16'(pull(en, pue)));
		end
		k = 3'(($random(seed) & 32'h7FFFFFFF) % 6);
		j = (k == 3'h5) ? 3'h0 : k + 3'h1;
		// Edge mode: latch, refuse, acknowledge
		arm(7'h3F, 1'b0);
		rdchk(8'h1A, scr(0, 0, 0));
		cyc(1);
		press[k] <= 1'b1;
		cyc(5);
		rdchk(8'h1A, scr(1, 0, 0));
		chk_sig(16'(cpu_request), 16'h0001);
		ack(1'b0);
		rdchk(8'h1A, scr(0, 0, 0));
		cyc(1);
		press[j] <= 1'b1;
		cyc(5);
		rdchk(8'h1A, scr(0, 0, 0));
		cyc(1);
		press[j] <= 1'b0;
		wr(8'h1B, 8'h3F & ~(8'h01 << k));
		cyc(5);
		press[j] <= 1'b1;
		cyc(5);
		rdchk(8'h1A, scr(1, 0, 0));
		vfetch();
		rdchk(8'h1A, scr(0, 0, 0));
		cyc(1);
		press <= 6'h00;
		// Mask hides the request, flag still shows it
		arm(7'h3F, 1'b0);
		rd(8'h30, d);
		wr(8'h31, 8'h02);
		wr(8'h1A, 8'h02);
		press[j] <= 1'b1;
		cyc(5);
		rdchk(8'h1A, scr(1, 1, 0));
		chk_sig(16'(cpu_request), 16'h0000);
		chk_sig(16'(irq), 16'h0000);
		wr(8'h31, 8'h03);
		@(negedge clock);
		chk_sig(16'(irq), 16'h0001);
		rdchk(8'h30, 8'h01);
		chk_sig(16'(irq), 16'h0000);
		cyc(1);
		press <= 6'h00;
		// Level mode, acknowledge before and after release
		arm(7'h3F, 1'b1);
		press[k] <= 1'b1;
		cyc(5);
		vfetch();
		cyc(2);
		rdchk(8'h1A, scr(1, 0, 1));
		cyc(1);
		press <= 6'h00;
		cyc(5);
		rdchk(8'h1A, scr(0, 0, 1));
		cyc(1);
		press[j] <= 1'b1;
		cyc(5);
		press <= 6'h00;
		cyc(5);
		rdchk(8'h1A, scr(1, 0, 1));
		ack(1'b1);
		rdchk(8'h1A, scr(0, 0, 1));
		// Wakeup latch survives a vector fetch
		arm(7'h40, 1'b1);
		@(posedge clock);
		awu <= 1'b1;
		@(posedge clock);
		awu <= 1'b0;
		cyc(4);
		vfetch();
		cyc(2);
		rdchk(8'h1A, scr(1, 0, 1));
		ack(1'b1);
		cyc(1);
		rdchk(8'h1A, scr(0, 0, 1));
		// Reset mid-run with a key held low
		arm(7'h3F, 1'b1);
		press[k] <= 1'b1;
		cyc(5);
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		rdchk(8'h1A, scr(0, 0, 0));
		cyc(1);
		press <= 6'h00;
		end_of_test();
	end

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#100000;
		n_errors++;
		end_of_test();
	end
endmodule // testbench
